// ==== rtl/dspiv_top.sv ====
/*
 * Interrupt prioritisation and vectoring. Keeps reset and soft reset in one
 * shared pending bit and nonmaskable requests in another, collects pin, timer, serial,
 * host and DMA requests into a pending flag register gated by an enable mask,
 * and offers the highest-priority request to the core as vector_base plus a vector offset, with a priority number.
 * Assumes peripheral and DMA event lines are one-cycle pulses on mclk,
 * pins and the nonmaskable input are asynchronous levels (edge-caught),
 * and the core pulses irq_ack in the cycle it takes the offered vector.
 */
module dspiv_top
    import dspiv_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Reset sources
    input  wire logic        reset_input_n,
    input  wire logic        soft_reset_trap,
    // Asynchronous pins, active low
    input  wire logic        nmi_n,
    input  wire logic        ext_request_0_n,
    input  wire logic        ext_request_1_n,
    input  wire logic        ext_request_2_n,
    input  wire logic        ext_request_3_n,
    // On-chip events, one-cycle pulses
    input  wire logic        timer_event,
    input  wire logic        serial0_rx_event,
    input  wire logic        serial0_tx_event,
    input  wire logic        serial1_rx_event,
    input  wire logic        serial1_tx_event,
    input  wire logic        serial2_rx_event,
    input  wire logic        serial2_tx_event,
    input  wire logic        host_port_event,
    input  wire logic        dma_ch0_event,
    input  wire logic        dma_ch1_event,
    input  wire logic        dma_ch2_event,
    input  wire logic        dma_ch3_event,
    input  wire logic        dma_ch4_event,
    input  wire logic        dma_ch5_event,
    // Source selection: 1 picks the DMA channel for the shared slot
    input  wire logic        dma01_select,
    input  wire logic        dma23_select,
    // Software access to flags and mask, and the vector base
    input  wire logic [15:0] mask_wdata,
    input  wire logic        mask_we,
    input  wire logic [15:0] flag_clear,
    input  wire logic        flag_clear_we,
    input  wire logic [15:0] vector_base,
    // Core side
    input  wire logic        irq_ack,
    output logic [15:0]      pending_flags,
    output logic [15:0]      enable_mask,
    output logic             irq_req,
    output logic [15:0]      irq_vector,
    output logic [4:0]       irq_priority,
    output logic             reset_req
);
    typedef struct packed {
        logic [15:0] flags;
        logic [15:0] mask;
        logic        nmi_pend;
        logic        nmi_last;
        logic [3:0]  pin_last;
        logic        rst_pend;
        logic        req;
        logic [6:0]  vec;
        logic [4:0]  prio;
    } dspiv_state_t;

    dspiv_state_t st_reg;
    dspiv_state_t st_next;

    logic [4:0]  pins_s;
    logic [15:0] ev;
    logic [15:0] live;
    logic        found;
    logic [3:0]  win;

    // Pins pass two flops before use
    dspiv_sync #(.W(5)) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     ({~nmi_n, ~ext_request_3_n, ~ext_request_2_n,
                 ~ext_request_1_n, ~ext_request_0_n}),
        .q     (pins_s)
    );

    // Priority number for a flag bit: bit order equals priority order
    function automatic logic [4:0] bit_prio(input logic [3:0] b);
        return PRIO_MASKABLE0 + {1'b0, b};
    endfunction

    // Event vector in flag layout; shared slots choose their source
    always_comb begin
        ev = '0;
        ev[BIT_EXT0]    = pins_s[0] & ~st_reg.pin_last[0];
        ev[BIT_EXT1]    = pins_s[1] & ~st_reg.pin_last[1];
        ev[BIT_EXT2]    = pins_s[2] & ~st_reg.pin_last[2];
        ev[BIT_TIMER]   = timer_event;
        ev[BIT_SER0_RX] = serial0_rx_event;
        ev[BIT_SER0_TX] = serial0_tx_event;
        ev[BIT_SER2_RX] = dma01_select ? dma_ch0_event
                                       : serial2_rx_event;
        ev[BIT_SER2_TX] = dma01_select ? dma_ch1_event
                                       : serial2_tx_event;
        ev[BIT_EXT3]    = pins_s[3] & ~st_reg.pin_last[3];
        ev[BIT_HOST]    = host_port_event;
        ev[BIT_SER1_RX] = dma23_select ? dma_ch2_event
                                       : serial1_rx_event;
        ev[BIT_SER1_TX] = dma23_select ? dma_ch3_event
                                       : serial1_tx_event;
        ev[BIT_DMA4]    = dma_ch4_event;
        ev[BIT_DMA5]    = dma_ch5_event;
    end

    // Same layout gates flags by mask; lowest bit wins
    assign live = st_reg.flags & st_reg.mask & FLAG_USED;
    always_comb begin
        found = 1'b0;
        win   = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (live[i]) begin
                found = 1'b1;
                win   = 4'(i);
            end
        end
    end

    // Next state: flag set wins over clear, ack clears the winner only
    always_comb begin
        st_next = st_reg;
        st_next.pin_last = pins_s[3:0];
        st_next.nmi_last = pins_s[4];
        st_next.rst_pend = ~reset_input_n | soft_reset_trap;
        if (mask_we) begin
            st_next.mask = mask_wdata & FLAG_USED;
        end
        if (flag_clear_we) begin
            st_next.flags = st_reg.flags & ~flag_clear;
        end
        if (irq_ack && st_reg.req && st_reg.prio >= PRIO_MASKABLE0) begin
            st_next.flags[st_reg.vec[5:2]] = 1'b0;
        end
        if (irq_ack && st_reg.req && st_reg.prio == PRIO_NMI) begin
            st_next.nmi_pend = 1'b0;
        end
        st_next.flags = (st_next.flags | ev) & FLAG_USED;
        if (pins_s[4] && !st_reg.nmi_last) begin
            st_next.nmi_pend = 1'b1;
        end
        // Offer registered after arbitration
        if (st_next.rst_pend) begin
            st_next.req   = 1'b1;
            st_next.vec   = VEC_RESET;
            st_next.prio  = PRIO_RESET;
            st_next.flags = FLAG_RESET;
            st_next.mask  = MASK_RESET;
            st_next.nmi_pend = 1'b0;
        end else if (st_next.nmi_pend) begin
            st_next.req  = 1'b1;
            st_next.vec  = VEC_NMI;
            st_next.prio = PRIO_NMI;
        end else begin
            st_next.req  = found && !(irq_ack && st_reg.req);
            st_next.vec  = VEC_MASKABLE0 + {1'b0, win, 2'b00};
            st_next.prio = found ? bit_prio(win) : PRIO_NONE;
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.vec  <= VEC_RESET;
            st_reg.prio <= PRIO_NONE;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs from the state register
    assign pending_flags = st_reg.flags;
    assign enable_mask   = st_reg.mask;
    assign irq_req       = st_reg.req;
    assign irq_vector    = vector_base + {9'h000, st_reg.vec};
    assign irq_priority  = st_reg.prio;
    assign reset_req     = st_reg.rst_pend;

    // Checks
    property p_reset_vec;
        @(posedge mclk) disable iff (!rst_n)
        st_reg.rst_pend |-> st_reg.vec == 7'h00 && st_reg.prio == 5'd1;
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("reset not at vector 00h prio 1");

    property p_nmi_vec;
        @(posedge mclk) disable iff (!rst_n)
        (st_reg.nmi_pend && !st_reg.rst_pend) |->
            st_reg.req && st_reg.vec == 7'h04 && st_reg.prio == 5'd2;
    endproperty
    a_nmi_vec: assert property (p_nmi_vec)
        else $error("nonmaskable not offered at 04h");

    property p_vec_prio;
        @(posedge mclk) disable iff (!rst_n)
        (irq_req && irq_priority >= 5'd3) |->
            st_reg.vec == 7'h40 + 7'((irq_priority - 5'd3) * 4);
    endproperty
    a_vec_prio: assert property (p_vec_prio)
        else $error("vector and priority disagree");

    property p_no_reserved;
        @(posedge mclk) disable iff (!rst_n)
        irq_req |-> st_reg.vec <= 7'h74;
    endproperty
    a_no_reserved: assert property (p_no_reserved)
        else $error("reserved vector offered");

    property p_reserved_bits;
        @(posedge mclk) disable iff (!rst_n)
        pending_flags[15:14] == 2'b00 && enable_mask[15:14] == 2'b00;
    endproperty
    a_reserved_bits: assert property (p_reserved_bits)
        else $error("reserved flag bit set");

    property p_masked_quiet;
        @(posedge mclk) disable iff (!rst_n)
        (irq_req && irq_priority >= 5'd3) |->
            enable_mask[st_reg.vec[5:2]];
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("masked source offered");

    property p_timer_flag;
        @(posedge mclk) disable iff (!rst_n)
        (timer_event && !st_next.rst_pend) |=> pending_flags[3];
    endproperty
    a_timer_flag: assert property (p_timer_flag)
        else $error("timer event lost");

    property p_lowest_first;
        @(posedge mclk) disable iff (!rst_n)
        (irq_req && irq_priority >= 5'd3) |->
            (live & ((16'h0001 << st_reg.vec[5:2]) - 16'h0001)) == 16'h0
            || $past(live) != live;
    endproperty
    a_lowest_first: assert property (p_lowest_first)
        else $error("lower priority served first");

    c_reset: cover property (@(posedge mclk) st_reg.rst_pend);
    c_nmi: cover property (@(posedge mclk) irq_req && irq_priority == 5'd2);
    c_dma5: cover property (@(posedge mclk) irq_req && st_reg.vec == 7'h74);
    c_two: cover property (@(posedge mclk) live[0] && live[13]);
endmodule // dspiv_top

// ==== rtl/dspiv_pkg.sv ====
/*
 * Constants for the interrupt prioritisation and vectoring block:
 * vector offsets, flag bit positions, priorities and reset values.
 * Assumes a single core clock and a synchronous active-low reset.
 */
package dspiv_pkg;
    localparam int          NUM_SRC        = 14;
    localparam int          VEC_W          = 7;
    localparam logic [15:0] FLAG_RESET     = 16'h0000;
    localparam logic [15:0] MASK_RESET     = 16'h0000;
    localparam logic [15:0] FLAG_USED      = 16'h3FFF;
    // Vector offsets
    localparam logic [6:0]  VEC_RESET      = 7'h00;
    localparam logic [6:0]  VEC_NMI        = 7'h04;
    localparam logic [6:0]  VEC_SOFT_FIRST = 7'h08;
    localparam logic [6:0]  VEC_SOFT_LAST  = 7'h3C;
    localparam logic [6:0]  VEC_MASKABLE0  = 7'h40;
    localparam logic [6:0]  VEC_STEP       = 7'h04;
    // Flag bit positions
    localparam int BIT_EXT0 = 0;
    localparam int BIT_EXT1 = 1;
    localparam int BIT_EXT2 = 2;
    localparam int BIT_TIMER = 3;
    localparam int BIT_SER0_RX = 4;
    localparam int BIT_SER0_TX = 5;
    localparam int BIT_SER2_RX = 6;
    localparam int BIT_SER2_TX = 7;
    localparam int BIT_EXT3 = 8;
    localparam int BIT_HOST = 9;
    localparam int BIT_SER1_RX = 10;
    localparam int BIT_SER1_TX = 11;
    localparam int BIT_DMA4 = 12;
    localparam int BIT_DMA5 = 13;
    // Priorities
    localparam logic [4:0] PRIO_RESET    = 5'h01;
    localparam logic [4:0] PRIO_NMI      = 5'h02;
    localparam logic [4:0] PRIO_MASKABLE0 = 5'h03;
    localparam logic [4:0] PRIO_NONE     = 5'h00;
endpackage

// ==== rtl/dspiv_sync.sv ====
/*
 * Two-flop synchroniser bank for the request pins.
 * Assumes inputs are asynchronous to mclk.
 */
module dspiv_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // Two stages; only the second stage is seen outside
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= d;
            q_reg    <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule // dspiv_sync

// ==== testbench/dspiv_core_model.sv ====
/* Core-side partner: takes an offered vector after a set delay.
   Assumes the offer stays up until the ack has been sampled. */
module dspiv_core_model (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Offer from the block
    input  wire logic        irq_req,
    input  wire logic [15:0] irq_vector,
    input  wire logic [4:0]  irq_priority,
    // Bench control
    input  wire logic        ack_en,
    input  wire logic [1:0]  ack_dly,
    // Ack and record of what was taken
    output logic             irq_ack,
    output logic [15:0]      taken_vec,
    output logic [4:0]       taken_prio,
    output int               taken_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_cnt;
    logic       hold;
    // Delay, one-cycle ack, then wait for the offer to drop
    always @(posedge mclk) begin
        if (!rst_n) begin
            irq_ack <= 1'b0;
            hold <= 1'b0;
            taken_cnt <= 0;
        end else if (irq_ack) begin
            irq_ack <= 1'b0;
            hold <= 1'b1;
            taken_vec <= irq_vector;
            taken_prio <= irq_priority;
            taken_cnt <= taken_cnt + 1;
        end else if (hold || !irq_req || !ack_en) begin
            hold <= hold && irq_req;
            wait_cnt <= ack_dly;
        end else if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end else begin
            irq_ack <= 1'b1;
        end
    end
endmodule // dspiv_core_model

// ==== testbench/tb_dspiv_top.sv ====
/* Bench for the vectoring block: reset offers, each source alone,
   random mixes under random masks, nonmaskable input.
   Assumes the core partner in dspiv_core_model. */
module tb_dspiv_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dspiv_pkg::*;
    logic        mclk, rst_n, reset_input_n, soft_reset_trap, nmi, nz;
    logic        s01, s23, mask_we, flag_clear_we, ack_en, irq_ack;
    logic        irq_req, reset_req;
    logic [13:0] ev;
    logic [1:0]  ack_dly;
    logic [15:0] mask_wdata, flag_clear, vector_base, pending_flags;
    logic [15:0] enable_mask, irq_vector, taken_vec;
    logic [4:0]  irq_priority, taken_prio;
    logic [31:0] seed;
    int          taken_cnt, error_cnt, samples_checked, cycles;

    // Block under test; unselected shared lines carry noise
    dspiv_top dspiv_top_i (.mclk, .rst_n, .reset_input_n, .soft_reset_trap,
        .nmi_n(~nmi), .ext_request_0_n(~ev[0]), .ext_request_1_n(~ev[1]),
        .ext_request_2_n(~ev[2]), .ext_request_3_n(~ev[8]),
        .timer_event(ev[3]), .serial0_rx_event(ev[4]),
        .serial0_tx_event(ev[5]), .serial2_rx_event(s01 ? nz : ev[6]),
        .serial2_tx_event(s01 ? nz : ev[7]), .dma_ch0_event(s01 ? ev[6] : nz),
        .dma_ch1_event(s01 ? ev[7] : nz), .host_port_event(ev[9]),
        .serial1_rx_event(s23 ? nz : ev[10]),
        .serial1_tx_event(s23 ? nz : ev[11]),
        .dma_ch2_event(s23 ? ev[10] : nz), .dma_ch3_event(s23 ? ev[11] : nz),
        .dma_ch4_event(ev[12]), .dma_ch5_event(ev[13]),
        .dma01_select(s01), .dma23_select(s23), .mask_wdata, .mask_we,
        .flag_clear, .flag_clear_we, .vector_base, .irq_ack, .pending_flags,
        .enable_mask, .irq_req, .irq_vector, .irq_priority, .reset_req);

    // Core partner
    dspiv_core_model dspiv_core_model_i (.mclk, .rst_n, .irq_req,
        .irq_vector, .irq_priority, .ack_en, .ack_dly, .irq_ack,
        .taken_vec, .taken_prio, .taken_cnt);

    // Clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Cycle count, noise pattern and hang limit
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        nz <= cycles[1];
        if (cycles == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Fire sources, then let the core take them in expected order
    task automatic trial(input logic [13:0] e, input logic [15:0] m,
                         input logic n, input logic [1:0] sel);
        logic [15:0] left;
        int i;
        int t;
        @(posedge mclk);
        ack_en <= 1'b0;
        mask_wdata <= m;
        mask_we <= 1'b1;
        ev <= e;
        nmi <= n;
        {s01, s23} <= sel;
        ack_dly <= sel;
        vector_base <= 16'(rnd());
        @(posedge mclk);
        mask_we <= 1'b0;
        ev <= 14'h0;
        nmi <= 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        chk("flags", pending_flags, {2'h0, e});
        chk("mask", enable_mask, m & 16'h3FFF);
        left = {2'h0, e} & m;
        t = taken_cnt;
        @(posedge mclk);
        ack_en <= 1'b1;
        while (n || left != 16'h0) begin
            i = 0;
            while (!n && !left[i]) i++;
            for (int k = 0; k < 60 && taken_cnt == t; k++) @(posedge mclk);
            #1;
            chk("ack", 16'(taken_cnt - t), 16'h1);
            chk("prio", 16'(taken_prio), n ? 16'(PRIO_NMI) :
                16'(PRIO_MASKABLE0) + 16'(i));
            chk("vec", taken_vec, vector_base + (n ? 16'(VEC_NMI) :
                16'(VEC_MASKABLE0) + 16'(VEC_STEP) * 16'(i)));
            t = taken_cnt;
            if (n) n = 1'b0;
            else left[i] = 1'b0;
        end
        repeat (4) @(posedge mclk);
        #1;
        chk("left", pending_flags, {2'h0, e} & ~m);
        chk("req", 16'(irq_req), 16'h0);
        @(posedge mclk);
        flag_clear <= 16'hFFFF;
        flag_clear_we <= 1'b1;
        @(posedge mclk);
        flag_clear_we <= 1'b0;
    endtask

    // Main sequence
    initial begin
        logic [31:0] r;
        {rst_n, soft_reset_trap, nmi, s01, s23, ev, ack_dly} = '0;
        {mask_we, flag_clear_we, ack_en, mask_wdata, flag_clear} = '0;
        reset_input_n = 1'b1;
        vector_base = 16'h1200;
        seed = 32'd7188;
        {error_cnt, samples_checked, cycles} = '0;
        repeat (11) @(posedge mclk);
        #1;
        chk("rvec", irq_vector, vector_base + 16'(VEC_RESET));
        chk("rflag", pending_flags, 16'h0000);
        @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1;
        chk("idle", 16'(irq_req), 16'h0);
        chk("iprio", 16'(irq_priority), 16'(PRIO_NONE));
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            reset_input_n <= k[0];
            soft_reset_trap <= k[0];
            repeat (3) @(posedge mclk);
            #1;
            chk("rreq", 16'(reset_req), 16'h1);
            chk("rprio", 16'(irq_priority), 16'(PRIO_RESET));
            chk("rvec", irq_vector, vector_base + 16'(VEC_RESET));
            @(posedge mclk);
            reset_input_n <= 1'b1;
            soft_reset_trap <= 1'b0;
            repeat (3) @(posedge mclk);
            #1;
            chk("rreq", 16'(reset_req), 16'h0);
        end
        for (int k = 0; k < 28; k++) begin
            trial(14'(1 << (k % 14)), 16'hFFFF, 1'b0, 2'(k / 14 * 3));
        end
        for (int k = 0; k < 20; k++) begin
            r = rnd();
            trial(r[13:0], r[29:14], 1'b0, r[31:30]);
        end
        trial(14'h0008, 16'h0000, 1'b1, 2'h0);
        trial(14'h0008, 16'h0008, 1'b1, 2'h3);
        report_and_stop();
    end
endmodule // tb_dspiv_top
